// ---- logic/uep_endpoints.sv ----
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
// What this block does
// - endpoint 0 transmit level reports free slots
// - stall request needs one bit clock lead
// - receive flush bit empties fifo, self-clears
// - low status byte updates at transaction end, except overrun bit 6
// - writing one clears low status bits
// - endpoint 0 receive ACK sent sets bit 0
// - CRC and timeout flags unless NAKed
// - receive data PID recorded in bit 4
// - bit 5 marks SETUP versus OUT token
// - receive overrun sets bit 6, withholds ACK
// - NAK bit sets on NAK, read clears
// - receive level field reports free slots
// - valid bytes of final received doubleword
// - read port pops receive fifo
// - write port pushes endpoint 0 transmit fifo
// - endpoint 1 enable off resets fifo, state
// - last data flag cleared after acknowledged send
// - toggle select picks DATA0 or DATA1
// - byte enables mark final transmit doubleword
// - transmit flush bit empties fifo, self-clears
// - endpoint 1 ACK received sets bit 0
// - transmit overrun flags error, forces stuff error
module uep_endpoints
  import uep_pkg::*;
(
  input  wire logic                       clk,      // 200 MHz system clock
  input  wire logic                       reset,    // sync reset, active high
  input  wire logic                       psel,     // apb select
  input  wire logic                       penable,  // apb access phase
  input  wire logic                       pwrite,   // apb write
  input  wire logic [uep_pkg::ADDR_W-1:0] paddr,    // apb byte address
  input  wire logic [uep_pkg::DATA_W-1:0] pwdata,   // apb write data
  output logic      [uep_pkg::DATA_W-1:0] prdata,   // apb read data
  output logic                            pready,   // apb ready
  output logic                            pslverr,  // apb error, unmapped
  input  wire uep_pkg::uep_sie_in_t       sieIn,    // from serial engine
  output uep_pkg::uep_sie_out_t           sieOut    // to serial engine
);

  // ==========================================================================
  // declarations
  logic [4:0]        bitCnt;
  logic              bitTick;
  logic              setupPh;
  logic              accessPh;
  logic              wrAcc;
  logic              rdAcc;
  logic              mapped;
  logic [DATA_W-1:0] rdMux;
  logic              tokDly;
  logic              tokRise;
  logic              endDly;
  logic              endRise;
  logic              curEp1;
  logic              curSetup;
  logic              ep0StallReq;
  logic              ep0Flush;
  logic              ep0StallArm;
  logic              ep1StallArm;
  logic              ep1On;
  logic              ep1LastLoaded;
  logic              ep1StallReq;
  logic              ep1Toggle;
  logic [3:0]        ep1ByteEn;
  logic              ep1Flush;
  logic [7:0]        rxStat;
  logic [1:0]        rxLastBytes;
  logic [7:0]        ep1Stat;
  logic              rxOverrunNow;
  logic              txOverrunNow;
  logic              rxOverrunTxn;
  logic              txOverrunTxn;
  logic [7:0]        wrClr;
  logic [DATA_W-1:0] rxHead;
  logic [LVL_W-1:0]  rxCount;
  logic              rxFull;
  logic              rxEmpty;
  logic [DATA_W-1:0] tx0Head;
  logic [LVL_W-1:0]  tx0Count;
  logic              tx0Empty;
  logic [DATA_W-1:0] tx1Head;
  logic [LVL_W-1:0]  tx1Count;
  logic              tx1Empty;
  logic              rxPush;
  logic              rxPop;
  logic              tx0Push;
  logic              tx1Push;
  logic              tx1Pop;

  // ==========================================================================
  // apb decode; zero wait states, read data latched in the setup phase
  assign pready = 1'b1;
  assign setupPh = psel && !penable;
  assign accessPh = psel && penable;
  assign wrAcc = accessPh && pwrite;
  assign rdAcc = accessPh && !pwrite;
  assign wrClr = pwdata[7:0];

  always_comb begin
    mapped = 1'b1;
    rdMux = '0;
    if (paddr == OFF_EP0_TX_STATUS) begin
      rdMux[BIT_LEVEL_LO +: LVL_W] = LVL_W'(FIFO_DEPTH) - tx0Count;
    end else if (paddr == OFF_EP0_RX_CONTROL) begin
      rdMux[BIT_STALL_REQUEST] = ep0StallReq;
      rdMux[BIT_FLUSH] = ep0Flush;
    end else if (paddr == OFF_EP0_RX_STATUS) begin
      rdMux[7:0] = rxStat;
      rdMux[BIT_LEVEL_LO +: LVL_W] = LVL_W'(FIFO_DEPTH) - rxCount;
      rdMux[BIT_LAST_BYTES_LO +: 2] = rxLastBytes;
    end else if (paddr == OFF_EP0_RX_FIFO_PORT) begin
      rdMux = rxEmpty ? '0 : rxHead;
    end else if (paddr == OFF_EP0_TX_FIFO_PORT) begin
      rdMux = '0;
    end else if (paddr == OFF_EP1_CONTROL) begin
      rdMux[BIT_ENDPOINT_ON] = ep1On;
      rdMux[BIT_LAST_DATA_LOADED] = ep1LastLoaded;
      rdMux[BIT_STALL_REQUEST] = ep1StallReq;
      rdMux[BIT_DATA_TOGGLE_SELECT] = ep1Toggle;
      rdMux[BIT_BYTE_EN_LO +: 4] = ep1ByteEn;
      rdMux[BIT_FLUSH] = ep1Flush;
    end else if (paddr == OFF_EP1_STATUS) begin
      rdMux[7:0] = ep1Stat;
    end else if (paddr == OFF_EP1_TX_FIFO_PORT) begin
      rdMux = '0;
    end else begin
      mapped = 1'b0;
    end
  end

  // read data and error held through the access phase
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setupPh) begin
      prdata <= pwrite ? '0 : rdMux;
      pslverr <= !mapped;
    end
  end

  // ==========================================================================
  // bit clock enable divider
  assign bitTick = (bitCnt == BIT_DIV_LAST);

  always_ff @(posedge clk) begin
    if (reset || bitTick) begin
      bitCnt <= 5'h0;
    end else begin
      bitCnt <= bitCnt + 5'h1;
    end
  end

  // ==========================================================================
  // token and transaction end edges, transaction context
  assign tokRise = sieIn.tokenValid && !tokDly;
  assign endRise = sieIn.transactionEnd && !endDly;

  always_ff @(posedge clk) begin
    if (reset) begin
      tokDly <= 1'b0;
      endDly <= 1'b0;
      curEp1 <= 1'b0;
      curSetup <= 1'b0;
    end else begin
      tokDly <= sieIn.tokenValid;
      endDly <= sieIn.transactionEnd;
      if (tokRise) begin
        curEp1 <= sieIn.tokenEp1;
        curSetup <= sieIn.tokenSetup;
      end
    end
  end

  // ==========================================================================
  // stall decisions: a request seen on a bit clock tick before the token
  // rises stalls this transaction; a later one is armed for the next
  always_ff @(posedge clk) begin
    if (reset) begin
      ep0StallArm <= 1'b0;
      ep1StallArm <= 1'b0;
      sieOut.stallEp0 <= 1'b0;
      sieOut.stallEp1 <= 1'b0;
    end else begin
      if (bitTick) begin
        ep0StallArm <= ep0StallReq;
        ep1StallArm <= ep1StallReq && ep1On;
      end
      if (tokRise) begin
        sieOut.stallEp0 <= ep0StallArm && !sieIn.tokenEp1;
        sieOut.stallEp1 <= ep1StallArm && sieIn.tokenEp1;
      end else if (endRise) begin
        sieOut.stallEp0 <= 1'b0;
        sieOut.stallEp1 <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // endpoint 0 receive control
  always_ff @(posedge clk) begin
    if (reset) begin
      ep0StallReq <= 1'b0;
      ep0Flush <= 1'b0;
    end else if (wrAcc && paddr == OFF_EP0_RX_CONTROL) begin
      ep0StallReq <= pwdata[BIT_STALL_REQUEST];
      ep0Flush <= pwdata[BIT_FLUSH];
    end else if (ep0Flush && rxEmpty) begin
      // flush done, bit returns to zero
      ep0Flush <= 1'b0;
    end
  end

  // ==========================================================================
  // endpoint 0 receive fifo; serial engine fills, read port drains
  assign rxPush = sieIn.rxValid && !curEp1;
  // push into a full fifo is an overrun, except under a SETUP token
  assign rxOverrunNow = rxPush && rxFull && !curSetup;
  // each port read pops one doubleword
  assign rxPop = rdAcc && paddr == OFF_EP0_RX_FIFO_PORT;

  uep_fifo rxFifo (
    .clk    (clk),
    .reset  (reset),
    .flush  (ep0Flush),
    .wrEn   (rxPush),
    .wrData (sieIn.rxData),
    .rdEn   (rxPop),
    .rdData (rxHead),
    .count  (rxCount),
    .full   (rxFull),
    .empty  (rxEmpty)
  );

  // ==========================================================================
  // endpoint 0 transmit fifo; write port fills, serial engine drains
  // each port write pushes one doubleword
  assign tx0Push = wrAcc && paddr == OFF_EP0_TX_FIFO_PORT;

  uep_fifo tx0Fifo (
    .clk    (clk),
    .reset  (reset),
    .flush  (1'b0),
    .wrEn   (tx0Push),
    .wrData (pwdata),
    .rdEn   (sieIn.ep0TxTake),
    .rdData (tx0Head),
    .count  (tx0Count),
    .full   (),
    .empty  (tx0Empty)
  );

  assign sieOut.ep0TxValid = !tx0Empty;
  assign sieOut.ep0TxData = tx0Head;

  // ==========================================================================
  // endpoint 0 receive status; hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      rxStat <= RST_STATUS;
      rxLastBytes <= RST_LAST_BYTES;
      rxOverrunTxn <= 1'b0;
    end else begin
      if (sieIn.rxValid && sieIn.rxLast && !curEp1) begin
        rxLastBytes <= sieIn.rxLastBytes;
      end
      // error held for the rest of the transaction
      if (rxOverrunNow) begin
        rxOverrunTxn <= 1'b1;
      end else if (endRise) begin
        rxOverrunTxn <= 1'b0;
      end
      // write one to clear; a read also clears the NAK bit
      if (wrAcc && paddr == OFF_EP0_RX_STATUS) begin
        rxStat <= rxStat & ~wrClr;
      end else if (rdAcc && paddr == OFF_EP0_RX_STATUS) begin
        rxStat[BIT_ST_NAK] <= 1'b0;
      end
      // bits 0 to 5 captured at the transaction end edge
      if (endRise && !curEp1) begin
        rxStat[BIT_ST_ACK] <= sieIn.ackSent;
        rxStat[BIT_ST_CRC] <= sieIn.crcError && !sieIn.nakIssued;
        rxStat[BIT_ST_TIMEOUT] <= sieIn.timeoutFlag && !sieIn.nakIssued;
        rxStat[BIT_ST_END] <= 1'b1;
        if (!sieIn.nakIssued) begin
          rxStat[BIT_ST_PID] <= sieIn.rxPid1;
        end
        rxStat[BIT_ST_SETUP] <= curSetup;
      end
      if (rxOverrunNow) begin
        rxStat[BIT_ST_OVERRUN] <= 1'b1;
      end
      if (endRise && !curEp1 && sieIn.nakIssued) begin
        rxStat[BIT_ST_NAK] <= 1'b1;
      end
    end
  end

  assign sieOut.ctrlEpReceiveOverrun = rxOverrunTxn;
  assign sieOut.withholdAck = rxOverrunTxn;

  // ==========================================================================
  // endpoint 1 control
  always_ff @(posedge clk) begin
    if (reset) begin
      ep1On <= 1'b0;
      ep1LastLoaded <= 1'b0;
      ep1StallReq <= 1'b0;
      ep1Toggle <= 1'b0;
      ep1ByteEn <= RST_BYTE_EN;
      ep1Flush <= 1'b0;
    end else if (wrAcc && paddr == OFF_EP1_CONTROL) begin
      ep1On <= pwdata[BIT_ENDPOINT_ON];
      ep1LastLoaded <= pwdata[BIT_LAST_DATA_LOADED] && pwdata[BIT_ENDPOINT_ON];
      ep1StallReq <= pwdata[BIT_STALL_REQUEST];
      ep1Toggle <= pwdata[BIT_DATA_TOGGLE_SELECT];
      // byte enables of the final doubleword
      ep1ByteEn <= pwdata[BIT_BYTE_EN_LO +: 4];
      ep1Flush <= pwdata[BIT_FLUSH];
    end else begin
      // disabled endpoint holds no pending data
      if (!ep1On) begin
        ep1LastLoaded <= 1'b0;
      end else if (endRise && curEp1 && sieIn.ackReceived && tx1Empty) begin
        ep1LastLoaded <= 1'b0;
      end
      // flush done, bit returns to zero
      if (ep1Flush && tx1Empty) begin
        ep1Flush <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // endpoint 1 transmit fifo
  assign tx1Push = wrAcc && paddr == OFF_EP1_TX_FIFO_PORT && ep1On;
  assign tx1Pop = sieIn.ep1TxTake && curEp1;
  // engine pulls a word that is not there
  assign txOverrunNow = tx1Pop && tx1Empty;

  // disable clears the fifo; so does the flush bit
  uep_fifo tx1Fifo (
    .clk    (clk),
    .reset  (reset),
    .flush  (ep1Flush || !ep1On),
    .wrEn   (tx1Push),
    .wrData (pwdata),
    .rdEn   (tx1Pop),
    .rdData (tx1Head),
    .count  (tx1Count),
    .full   (),
    .empty  (tx1Empty)
  );

  assign sieOut.ep1Ready = ep1On && ep1LastLoaded;
  assign sieOut.ep1TxValid = ep1On && !tx1Empty;
  assign sieOut.ep1TxData = tx1Head;
  // final word once the cpu has marked data complete
  assign sieOut.ep1TxLast = ep1LastLoaded && (tx1Count == 3'h1);
  assign sieOut.ep1ByteEn = ep1ByteEn;
  // PID chosen by the toggle select bit
  assign sieOut.ep1Pid1 = ep1Toggle;

  // ==========================================================================
  // endpoint 1 status; hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (reset || !ep1On) begin
      ep1Stat <= RST_STATUS;
      txOverrunTxn <= 1'b0;
    end else begin
      // error and forced stuff error for the transaction
      if (txOverrunNow) begin
        txOverrunTxn <= 1'b1;
      end else if (endRise) begin
        txOverrunTxn <= 1'b0;
      end
      if (wrAcc && paddr == OFF_EP1_STATUS) begin
        ep1Stat <= ep1Stat & ~wrClr;
      end
      // captured at the transaction end edge
      if (endRise && curEp1) begin
        ep1Stat[BIT_ST_ACK] <= sieIn.ackReceived;
        ep1Stat[BIT_ST_CRC] <= sieIn.crcError && !sieIn.nakIssued;
        ep1Stat[BIT_ST_TIMEOUT] <= sieIn.timeoutFlag && !sieIn.nakIssued;
        ep1Stat[BIT_ST_END] <= 1'b1;
        if (sieIn.nakIssued) begin
          ep1Stat[BIT_ST_NAK] <= 1'b1;
        end
      end
      if (txOverrunNow) begin
        ep1Stat[BIT_ST_OVERRUN] <= 1'b1;
      end
    end
  end

  // transmit error and forced stuff error
  assign sieOut.intrEpTransmitOverrun = txOverrunTxn;
  assign sieOut.forceStuffError = txOverrunTxn;

endmodule

// ---- logic/uep_fifo.sv ----
`timescale 1ns/10ps
module uep_fifo
  import uep_pkg::*;
(
  input  wire logic                     clk,      // system clock
  input  wire logic                     reset,    // sync reset, active high
  input  wire logic                     flush,    // empty the fifo
  input  wire logic                     wrEn,     // push request
  input  wire logic [uep_pkg::DATA_W-1:0] wrData, // push data
  input  wire logic                     rdEn,     // pop request
  output logic      [uep_pkg::DATA_W-1:0] rdData, // head word
  output logic      [uep_pkg::LVL_W-1:0]  count,  // stored entries 0..4
  output logic                          full,     // four entries held
  output logic                          empty     // nothing held
);

  logic [DATA_W-1:0] mem [FIFO_DEPTH];
  logic [1:0]        wrPtr;
  logic [1:0]        rdPtr;
  logic              doWr;
  logic              doRd;

  // a push to a full or pop from an empty fifo is dropped, never wraps
  assign doWr = wrEn && !full;
  assign doRd = rdEn && !empty;
  assign full = (count == LVL_W'(FIFO_DEPTH));
  assign empty = (count == '0);
  assign rdData = mem[rdPtr];

  // ==========================================================================
  // pointers and count
  always_ff @(posedge clk) begin
    if (reset || flush) begin
      wrPtr <= 2'h0;
      rdPtr <= 2'h0;
      count <= '0;
    end else begin
      if (doWr) begin
        wrPtr <= wrPtr + 2'h1;
      end
      if (doRd) begin
        rdPtr <= rdPtr + 2'h1;
      end
      if (doWr && !doRd) begin
        count <= count + 3'h1;
      end else if (doRd && !doWr) begin
        count <= count - 3'h1;
      end
    end
  end

  // storage needs no reset, reads are gated by count
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr] <= wrData;
    end
  end

endmodule

// ---- logic/uep_pkg.sv ----
package uep_pkg;

  // ==========================================================================
  // bus and data widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int LVL_W = 3;

  // ==========================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_EP0_TX_STATUS = 16'h1010;
  localparam logic [ADDR_W-1:0] OFF_EP0_RX_CONTROL = 16'h1014;
  localparam logic [ADDR_W-1:0] OFF_EP0_RX_STATUS = 16'h1018;
  localparam logic [ADDR_W-1:0] OFF_EP0_RX_FIFO_PORT = 16'h101c;
  localparam logic [ADDR_W-1:0] OFF_EP0_TX_FIFO_PORT = 16'h1020;
  localparam logic [ADDR_W-1:0] OFF_EP1_CONTROL = 16'h1024;
  localparam logic [ADDR_W-1:0] OFF_EP1_STATUS = 16'h1028;
  localparam logic [ADDR_W-1:0] OFF_EP1_TX_FIFO_PORT = 16'h102c;

  // ==========================================================================
  // control field positions
  localparam int BIT_ENDPOINT_ON = 0;
  localparam int BIT_LAST_DATA_LOADED = 1;
  localparam int BIT_STALL_REQUEST = 2;
  localparam int BIT_DATA_TOGGLE_SELECT = 3;
  localparam int BIT_BYTE_EN_LO = 4;
  localparam int BIT_FLUSH = 8;

  // status field positions
  localparam int BIT_ST_ACK = 0;
  localparam int BIT_ST_CRC = 1;
  localparam int BIT_ST_TIMEOUT = 2;
  localparam int BIT_ST_END = 3;
  localparam int BIT_ST_PID = 4;
  localparam int BIT_ST_SETUP = 5;
  localparam int BIT_ST_OVERRUN = 6;
  localparam int BIT_ST_NAK = 7;
  localparam int BIT_LEVEL_LO = 9;
  localparam int BIT_LAST_BYTES_LO = 12;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [3:0] RST_BYTE_EN = 4'hf;
  localparam logic [1:0] RST_LAST_BYTES = 2'h0;

  // ==========================================================================
  // bit clock enable: one bit period is a least time, so round up
  localparam int CLK_HZ = 200_000_000;
  localparam int BIT_CLK_HZ = 12_000_000;
  localparam int BIT_DIV = (CLK_HZ + BIT_CLK_HZ - 1) / BIT_CLK_HZ;
  localparam logic [4:0] BIT_DIV_LAST = 5'(BIT_DIV - 1);

  // ==========================================================================
  // serial engine side carriers
  typedef struct packed {
    logic              tokenValid;   // token-valid strobe, level
    logic              tokenEp1;     // token addresses endpoint 1
    logic              tokenSetup;   // token is SETUP (else OUT/IN)
    logic              rxValid;      // one received doubleword
    logic [DATA_W-1:0] rxData;       // received doubleword
    logic              rxLast;       // final doubleword of packet
    logic [1:0]        rxLastBytes;  // valid bytes code of final word
    logic              rxPid1;       // received data PID was DATA1
    logic              ep0TxTake;    // engine takes endpoint 0 word
    logic              ep1TxTake;    // engine takes endpoint 1 word
    logic              ackSent;      // ACK sent to host
    logic              ackReceived;  // ACK received from host
    logic              crcError;     // CRC error seen
    logic              timeoutFlag;  // device timeout
    logic              nakIssued;    // NAK issued this transaction
    logic              transactionEnd; // end of transaction, level
  } uep_sie_in_t;

  typedef struct packed {
    logic              stallEp0;     // stall current endpoint 0 transaction
    logic              stallEp1;     // stall current endpoint 1 transaction
    logic              withholdAck;  // do not ACK (receive overrun)
    logic              ctrlEpReceiveOverrun;  // endpoint 0 receive error
    logic              intrEpTransmitOverrun; // endpoint 1 transmit error
    logic              forceStuffError;       // corrupt outgoing packet
    logic              ep0TxValid;   // endpoint 0 word available
    logic [DATA_W-1:0] ep0TxData;    // endpoint 0 head word
    logic              ep1Ready;     // endpoint 1 on and data complete
    logic              ep1TxValid;   // endpoint 1 word available
    logic [DATA_W-1:0] ep1TxData;    // endpoint 1 head word
    logic              ep1TxLast;    // head word is the final one
    logic [3:0]        ep1ByteEn;    // valid bytes of final word
    logic              ep1Pid1;      // send with DATA1 PID
  } uep_sie_out_t;

endpackage

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  import uep_pkg::*;
  logic                clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata, prdata, q;
  uep_sie_in_t         sieIn;
  uep_sie_out_t        sieOut;
  int                  errors, n_tests;
  // address and reset value of each readable register except endpoint 1 control and the two transmit fifo ports
  logic [47:0]         rows [5] = '{{16'h1010, 32'h800}, {16'h1014, 32'h0},
    {16'h1018, 32'h800}, {16'h101c, 32'h0}, {16'h1028, 32'h0}};
  uep_endpoints uep_endpoints_inst (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sieIn, .sieOut);
  uep_host_model uep_host_model_inst (.clk, .s(sieIn));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================================
  // apb master: request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
    // let the access edge settle so direct output checks see its effect
    @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(0, a, 0);
    chk(q & m, e);
  endtask
  task automatic summarize();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #100us;
    errors++;
    summarize();
  end
  initial begin
    {psel, penable, pwrite} = 3'b000;
    paddr = '0;
    pwdata = '0;
    errors = 0;
    n_tests = 0;
    reset = 1;
    repeat (8) @(posedge clk);
    reset <= 0;
    for (int i = 0; i < 5; i++) rc(rows[i][47:32], '1, rows[i][31:0]);
    apb(0, 16'h1000, 0);
    chk(pslverr, 1);
    $display("reset done");
    uep_host_model_inst.txn(0, 0, 3, 6'h11);
    rc(16'h1018, '1, 32'h1219);
    for (int i = 0; i < 3; i++) rc(16'h101c, '1, 32'ha0 + i);
    rc(16'h1018, 32'he00, 32'h800);
    apb(1, 16'h1018, 32'hff);
    rc(16'h1018, 32'hff, 0);
    uep_host_model_inst.txn(0, 1, 0, 6'h06);
    rc(16'h1018, 32'hff, 32'h2e);
    apb(1, 16'h1018, 32'hff);
    uep_host_model_inst.txn(0, 0, 0, 6'h0a);
    rc(16'h1018, 32'h82, 32'h80);
    rc(16'h1018, 32'h80, 0);
    uep_host_model_inst.txn(0, 0, 5, 0);
    rc(16'h1018, 32'he40, 32'h40);
    apb(1, 16'h1014, 32'h100);
    repeat (4) @(posedge clk);
    rc(16'h1014, 32'h100, 0);
    rc(16'h1018, 32'he00, 32'h800);
    $display("rx done");
    apb(1, 16'h1020, 32'h11);
    apb(1, 16'h1020, 32'h22);
    rc(16'h1010, 32'he00, 32'h400);
    chk(sieOut.ep0TxData, 32'h11);
    apb(1, 16'h1024, 32'h39);
    apb(1, 16'h102c, 32'h5);
    apb(1, 16'h102c, 32'h6);
    apb(1, 16'h1024, 32'h3b);
    chk({sieOut.ep1Ready, sieOut.ep1Pid1, sieOut.ep1ByteEn}, 6'h33);
    uep_host_model_inst.txn(1, 0, 2, 6'h20);
    rc(16'h1024, 32'h2, 0);
    rc(16'h1028, 32'hff, 32'h09);
    apb(1, 16'h1028, 32'hff);
    uep_host_model_inst.txn(1, 0, 1, 0);
    rc(16'h1028, 32'h40, 32'h40);
    apb(1, 16'h102c, 32'h7);
    apb(1, 16'h1024, 0);
    chk(sieOut.ep1TxValid, 0);
    rc(16'h1028, '1, 0);
    apb(1, 16'h1024, 32'h1);
    apb(1, 16'h102c, 32'h8);
    apb(1, 16'h1024, 32'h101);
    repeat (4) @(posedge clk);
    rc(16'h1024, 32'h100, 0);
    chk(sieOut.ep1TxValid, 0);
    $display("tx done");
    apb(1, 16'h1014, 32'h4);
    repeat (40) @(posedge clk);
    fork
      uep_host_model_inst.txn(0, 0, 2, 0);
      begin
        repeat (3) @(posedge clk);
        #1 chk(sieOut.stallEp0, 1);
      end
    join
    apb(1, 16'h1014, 0);
    $display("stall done");
    summarize();
  end
endmodule

// ---- tb/uep_chk.sv ----
`timescale 1ns/10ps
module uep_chk
  import uep_pkg::*;
(
  input wire logic                       clk,     // system clock
  input wire logic                       reset,   // sync reset
  input wire logic                       psel,    // apb select
  input wire logic                       penable, // apb access
  input wire logic [uep_pkg::ADDR_W-1:0] paddr,   // apb address
  input wire logic                       pready,  // apb ready
  input wire logic                       pslverr, // apb error
  input wire uep_pkg::uep_sie_in_t       sieIn,   // engine inputs
  input wire uep_pkg::uep_sie_out_t      sieOut   // engine outputs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // bus answers: zero wait states, so the master never stalls
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (psel && !penable && paddr == 16'h1000 |=> pslverr)
    else $error("no error on unmapped");
  a_mapped_ok: assert property (psel && !penable && paddr == 16'h1018 |=> !pslverr)
    else $error("error on mapped");
  // ==========================================================================
  // engine handshakes
  a_stall_start: assert property ($rose(sieOut.stallEp0) |-> $past(sieIn.tokenValid))
    else $error("stall without token");
  a_stall_end: assert property ($rose(sieIn.transactionEnd)
    |=> !sieOut.stallEp0 && !sieOut.stallEp1)
    else $error("stall past end");
  a_rx_err_end: assert property ($rose(sieIn.transactionEnd)
    |=> !sieOut.ctrlEpReceiveOverrun)
    else $error("rx error past end");
  a_ack_withhold: assert property (sieOut.withholdAck == sieOut.ctrlEpReceiveOverrun)
    else $error("ack not withheld");
  a_tx_err_cause: assert property ($rose(sieOut.intrEpTransmitOverrun)
    |-> $past(sieIn.ep1TxTake) && !$past(sieOut.ep1TxValid))
    else $error("tx error without cause");
  a_stuff_pair: assert property (sieOut.forceStuffError == sieOut.intrEpTransmitOverrun)
    else $error("stuff error mismatch");
  a_last_ready: assert property (sieOut.ep1TxLast |-> sieOut.ep1TxValid && sieOut.ep1Ready)
    else $error("last word not ready");
endmodule
bind uep_endpoints uep_chk uep_chk_inst (.clk, .reset, .psel, .penable, .paddr, .pready,
  .pslverr, .sieIn, .sieOut);

// ---- tb/uep_host_model.sv ----
`timescale 1ns/10ps
module uep_host_model
  import uep_pkg::*;
(
  input wire logic           clk, // system clock
  output uep_pkg::uep_sie_in_t s  // engine lines
);
  import uep_pkg::*;
  initial s = '0;
  // ==========================================================================
  // token, words, then end
  // f: 0 ack sent, 1 crc, 2 timeout, 3 nak, 4 pid1, 5 ack received
  task automatic txn(input logic ep1, input logic stp, input int nw, input logic [5:0] f);
    @(posedge clk) begin
      s.tokenValid <= 1'b1;
      s.tokenEp1 <= ep1;
      s.tokenSetup <= stp;
    end
    for (int i = 0; i < nw; i++) begin
      @(posedge clk) begin
        s.rxValid <= !ep1;
        s.ep1TxTake <= ep1;
        s.rxData <= 32'ha0 + 32'(i);
        s.rxLast <= (i == nw - 1);
        s.rxLastBytes <= 2'h1;
      end
    end
    // idle data line toggles so a stale word never looks valid
    @(posedge clk) begin
      s.rxValid <= 1'b0;
      s.ep1TxTake <= 1'b0;
      s.rxLast <= 1'b0;
      s.rxData <= ~s.rxData;
      {s.ackReceived, s.rxPid1, s.nakIssued, s.timeoutFlag, s.crcError, s.ackSent} <= f;
      s.transactionEnd <= 1'b1;
    end
    @(posedge clk) begin
      s.transactionEnd <= 1'b0;
      s.tokenValid <= 1'b0;
    end
  endtask
endmodule
